// [hw/fast_bus_port_consts.svh]
// constants for the fast bus fifo port: sizes, timing and reset values
`ifndef FAST_BUS_PORT_CONSTS_SVH
`define FAST_BUS_PORT_CONSTS_SVH
`define DATA_WIDTH 16
`define ADDR_WIDTH 5
`define FIFO_DEPTH 16
`define FIFO_PTR_WIDTH 4
`define FIFO_CNT_WIDTH 5
`define BLOCK_WORDS 5'h08
`define MASTER_CLOCK_HZ 19922944
`define HALF_RATE_DIVIDE 2
`define BUF_DEPTH 2
`define DATA_RESET 16'h0000
`define IRQ_LEVEL_WORDS 5'h10
`endif

// [hw/fast_bus_port_pkg.sv]
// types for the fast bus fifo port
`default_nettype none
`include "fast_bus_port_consts.svh"
package fast_bus_port_pkg;
   typedef logic [`DATA_WIDTH-1:0] word_t;
   typedef logic [`ADDR_WIDTH-1:0] addr_t;
   // block handshake progress
   typedef enum logic [1:0] {
      st_fill = 2'b00,
      st_avail = 2'b01,
      st_drain = 2'b10
   } block_state_t;
endpackage
`default_nettype wire

// [hw/fast_bus_fifo_port.sv]
// fast bus slave port with block fifo streaming collected words to the processor
`timescale 1ns/10ps
`default_nettype none
`include "fast_bus_port_consts.svh"

// Function
// - data lines driven only on reads
// - gate array I/O only under sync select
// - low acknowledge ends async cycles
// - block available low after full block
// - each read enable pulse moves one word once a block is announced
// - word ready low when word present
// - interrupt driven low on request
// - timing from the master clock
// - half rate clock is master divided two
// - gate array access timed by strobe clock
// - high buffered reset clears all logic but the skid and block storage
module fast_bus_fifo_port (
   input wire logic clock_i, // master timing clock, 20 MHz
   input wire logic rst_i, // buffered reset, active high here
   input wire fast_bus_port_pkg::word_t fast_data_lines_i, // data lines sensed
   output logic [`DATA_WIDTH-1:0] fast_data_lines_o, // data lines driven
   output logic fast_data_lines_oe_n_o, // low while we drive data
   input wire logic fast_read_write_i, // high read, low write
   input wire fast_bus_port_pkg::addr_t fast_address_lines_i, // circuit select
   input wire logic async_cycle_select_n_i, // asynchronous cycle in progress
   input wire logic sync_cycle_select_n_i, // synchronous cycle in progress
   input wire logic bus_strobe_clock_i, // strobe for gate array access
   input wire logic word_transfer_enable_n_i, // one low pulse per word
   input wire logic irq_request_i, // collection side asks for service
   input wire fast_bus_port_pkg::word_t collect_data_i, // collected word
   input wire logic collect_valid_i, // collected word valid
   output logic collect_ready_o, // room for a collected word
   output logic transfer_ack_n_o, // ends asynchronous cycles
   output logic block_available_n_o, // complete block waiting
   output logic word_ready_n_o, // a word is ready
   output logic fast_bus_irq_n_o, // interrupt to processor
   output logic half_rate_clock_o, // master clock divided by two
   output logic gate_array_io_en_o, // gate array and dac i/o enable
   output logic [`DATA_WIDTH-1:0] gate_array_wdata_o, // write data to gate arrays
   output logic [`ADDR_WIDTH-1:0] gate_array_addr_o, // target circuit
   output logic gate_array_write_o // gate array write pulse
);
   import fast_bus_port_pkg::*;

   // ********************************
   // input skid buffer, two entries
   // ********************************
   word_t skid_mem [0:`BUF_DEPTH-1]; // skid storage
   logic skid_wr; // write pointer
   logic skid_rd; // read pointer
   logic [1:0] skid_cnt; // entries held
   wire skid_valid = (skid_cnt != 2'h0);
   wire skid_take; // fifo accepts a word
   // a word moves in from the collection side on this edge
   wire skid_accept = collect_valid_i && collect_ready_o;
   // entries held after this edge, so ready can be decided ahead of time
   wire [1:0] skid_next_cnt = skid_cnt + {1'b0, skid_accept} - {1'b0, skid_take};

   // ********************************
   // block fifo
   // ********************************
   word_t fifo_mem [0:`FIFO_DEPTH-1]; // block storage
   logic [`FIFO_PTR_WIDTH-1:0] wr_ptr; // write index
   logic [`FIFO_PTR_WIDTH-1:0] rd_ptr; // oldest word index
   logic [`FIFO_CNT_WIDTH-1:0] fifo_cnt; // words held
   logic [`FIFO_CNT_WIDTH-1:0] drain_left; // words still owed from block
   block_state_t state; // handshake state
   block_state_t next_state; // next handshake state
   logic enable_d; // enable line one cycle ago
   logic strobe_d; // strobe one cycle ago

   // a full fifo stalls the skid buffer and raises the interrupt; no word is dropped
   wire fifo_full = (fifo_cnt == `FIFO_CNT_WIDTH'(`FIFO_DEPTH));
   assign skid_take = skid_valid && !fifo_full;
   // a falling edge of the enable is one word, however long the pulse lasts
   wire enable_fall = enable_d && !word_transfer_enable_n_i;
   wire pop = enable_fall && fast_read_write_i && (fifo_cnt != 5'h00)
              && (state != st_fill);
   wire async_read = !async_cycle_select_n_i && fast_read_write_i;
   wire sync_sel = !sync_cycle_select_n_i;
   // gate array access lands on the strobe's rising edge
   wire strobe_rise = !strobe_d && bus_strobe_clock_i;
   wire drive_bus = !word_transfer_enable_n_i && fast_read_write_i;

   // skid buffer: takes from collection, drains into block fifo
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         skid_wr <= 1'b0;
         skid_rd <= 1'b0;
         skid_cnt <= 2'h0;
      end else begin
         if (skid_accept) begin
            skid_wr <= ~skid_wr;
         end
         if (skid_take) begin
            skid_rd <= ~skid_rd;
         end
         skid_cnt <= skid_next_cnt;
      end
   end

   // skid storage has no reset: a slot is read only after it was written
   always_ff @(posedge clock_i) begin
      if (skid_accept) begin
         skid_mem[skid_wr] <= collect_data_i;
      end
   end

   // ready comes from a flop; it only rises when a slot surely frees
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         collect_ready_o <= 1'b0;
      end else begin
         // a held word still leaves room for one more, so ready falls only
         // when both slots will be full; a stalled fifo is what fills them
         collect_ready_o <= (skid_next_cnt != 2'h2);
      end
   end

   // block fifo storage and pointers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fifo_cnt <= '0;
      end else begin
         if (skid_take) begin
            wr_ptr <= wr_ptr + 4'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 4'h1; // oldest first
         end
         fifo_cnt <= fifo_cnt + {4'h0, skid_take} - {4'h0, pop};
      end
   end

   // block storage has no reset either, which keeps it plain memory
   always_ff @(posedge clock_i) begin
      if (skid_take) begin
         fifo_mem[wr_ptr] <= skid_mem[skid_rd];
      end
   end

   // block state: fill, announce, drain until the block is gone
   always_comb begin
      next_state = state;
      unique case (state)
         st_fill: begin
            if (fifo_cnt >= `BLOCK_WORDS) next_state = st_avail;
         end
         st_avail: begin
            if (pop) next_state = st_drain;
         end
         st_drain: begin
            // last word of the block taken, release the line
            if (pop && drain_left == 5'h01) next_state = st_fill;
         end
         default: next_state = st_fill;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state <= st_fill;
         drain_left <= '0;
         enable_d <= 1'b1;
         strobe_d <= 1'b0;
      end else begin
         state <= next_state;
         enable_d <= word_transfer_enable_n_i;
         strobe_d <= bus_strobe_clock_i;
         if (state == st_fill && next_state == st_avail) begin
            drain_left <= `BLOCK_WORDS;
         end else if (pop && drain_left != 5'h00) begin
            drain_left <= drain_left - 5'h01;
         end
      end
   end

   // ********************************
   // bus side outputs, all registered
   // ********************************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fast_data_lines_o <= `DATA_RESET;
         fast_data_lines_oe_n_o <= 1'b1;
         transfer_ack_n_o <= 1'b1;
         block_available_n_o <= 1'b1;
         word_ready_n_o <= 1'b1;
         fast_bus_irq_n_o <= 1'b1;
         half_rate_clock_o <= 1'b0;
         gate_array_io_en_o <= 1'b0;
         gate_array_wdata_o <= `DATA_RESET;
         gate_array_addr_o <= '0;
         gate_array_write_o <= 1'b0;
      end else begin
         // the oldest word stands before the pulse and, reloaded from the old
         // index on the pop edge, through the cycle in which the lines drive
         fast_data_lines_o <= fifo_mem[rd_ptr];
         fast_data_lines_oe_n_o <= !(drive_bus || async_read);
         // ack holds low for as long as the select stays low
         transfer_ack_n_o <= async_cycle_select_n_i;
         block_available_n_o <= !(next_state != st_fill);
         word_ready_n_o <= !(fifo_cnt - {4'h0, pop} + {4'h0, skid_take}
                             != 5'h00);
         // a full fifo also asks for service so nothing is lost
         fast_bus_irq_n_o <= !(irq_request_i || fifo_full);
         half_rate_clock_o <= ~half_rate_clock_o;
         gate_array_io_en_o <= sync_sel;
         gate_array_addr_o <= fast_address_lines_i;
         gate_array_wdata_o <= fast_data_lines_i;
         gate_array_write_o <= sync_sel && strobe_rise && !fast_read_write_i;
      end
   end
endmodule
`default_nettype wire

// [testbench/fast_bus_fifo_port_sva.sv]
// checker for the fast bus fifo port
`timescale 1ns/10ps
`default_nettype none
module fast_bus_fifo_port_chk (
   input wire logic clock_i, // clock
   input wire logic rst_i, // reset
   input wire logic fast_read_write_i, // dir
   input wire logic async_cycle_select_n_i, // async
   input wire logic sync_cycle_select_n_i, // sync
   input wire logic bus_strobe_clock_i, // strobe
   input wire logic irq_request_i, // ask
   input wire logic collect_valid_i, // valid
   input wire logic collect_ready_o, // ready
   input wire logic fast_data_lines_oe_n_o, // drive
   input wire logic transfer_ack_n_o, // ack
   input wire logic word_ready_n_o, // word
   input wire logic fast_bus_irq_n_o, // irq
   input wire logic half_rate_clock_o, // half
   input wire logic gate_array_io_en_o, // io
   input wire logic gate_array_write_o // write
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // a taken word must show as ready within the skid latency
   sequence s_take; collect_valid_i && collect_ready_o; endsequence
   sequence s_word; ##[1:3] !word_ready_n_o; endsequence
   property p_word; s_take |-> s_word; endproperty
   a_word: assert property (p_word) else $error("word ready late");
   property p_ack; $fell(async_cycle_select_n_i) |=> !transfer_ack_n_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_io; !sync_cycle_select_n_i |=> gate_array_io_en_o; endproperty
   a_io: assert property (p_io) else $error("io enable missing");
   property p_wr; $rose(bus_strobe_clock_i) && !sync_cycle_select_n_i
      && !fast_read_write_i |=> gate_array_write_o; endproperty
   a_wr: assert property (p_wr) else $error("write pulse missing");
   property p_half; half_rate_clock_o |=> !half_rate_clock_o; endproperty
   a_half: assert property (p_half) else $error("half clock stuck");
   property p_irq; irq_request_i |=> !fast_bus_irq_n_o; endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   // a write cycle must never find the device driving the lines
   property p_quiet; !fast_read_write_i |=> fast_data_lines_oe_n_o; endproperty
   a_quiet: assert property (p_quiet) else $error("drive in write");
   property p_drv; !async_cycle_select_n_i && fast_read_write_i
      |=> !fast_data_lines_oe_n_o; endproperty
   a_drv: assert property (p_drv) else $error("no drive in read");
endmodule
bind fast_bus_fifo_port fast_bus_fifo_port_chk fast_bus_fifo_port_chk_inst (.*);
`default_nettype wire

// [testbench/cpu_fast_bus_model.sv]
// processor side model of the fast bus
`timescale 1ns/10ps
`default_nettype none
module cpu_fast_bus_model import fast_bus_port_pkg::*; (
   input wire logic clock_i, // clock
   input wire logic blk_n_i, // block waiting
   input wire logic ack_n_i, // cycle end
   input wire word_t dev_data_i, // device data
   input wire logic dev_oe_n_i, // device drives
   output var word_t data_o, // resolved lines
   output logic rw_o, // read high
   output logic async_n_o, // async select
   output logic sync_n_o, // sync select
   output logic strobe_o, // strobe
   output logic en_n_o, // word enable
   output addr_t addr_o // circuit address
);
   word_t wdata = 16'h0000; // own write data
   logic own = 1'b0; // we drive on writes
   initial {rw_o, async_n_o, sync_n_o, strobe_o, en_n_o, addr_o} = 10'h3a0;
   // released lines show the inverse so stale data never passes
   assign data_o = !dev_oe_n_i ? dev_data_i : (own ? wdata : ~wdata);
   task async_cycle(input logic rd, output logic oe);
      rw_o = rd; own = !rd; async_n_o = 1'b0;
      @(negedge clock_i);
      while (ack_n_i) @(negedge clock_i);
      oe = dev_oe_n_i;
      async_n_o = 1'b1; own = 1'b0; rw_o = 1'b1;
      @(negedge clock_i);
   endtask
   task sync_write(input addr_t a, input word_t d);
      sync_n_o = 1'b0; rw_o = 1'b0; own = 1'b1; addr_o = a; wdata = d;
      @(negedge clock_i); strobe_o = 1'b1;
      @(negedge clock_i); strobe_o = 1'b0;
      @(negedge clock_i); sync_n_o = 1'b1; own = 1'b0; rw_o = 1'b1;
   endtask
   // one low enable pulse per word, only once a block is announced;
   // the word is taken off the resolved lines while the device drives them
   task pop(output word_t w, output logic oe);
      while (blk_n_i) @(negedge clock_i);
      en_n_o = 1'b0;
      @(negedge clock_i); oe = dev_oe_n_i;
      w = data_o;
      en_n_o = 1'b1; repeat (2) @(negedge clock_i);
   endtask
endmodule
`default_nettype wire

// [testbench/fast_bus_fifo_port_tb_top.sv]
// testbench for the fast bus fifo port
`timescale 1ns/10ps
`default_nettype none
module fast_bus_fifo_port_tb_top;
   import fast_bus_port_pkg::*;
   logic clock_i = 1'b0, rst_i = 1'b1, irq_request_i = 1'b0, collect_valid_i = 1'b0;
   word_t collect_data_i = 16'h0000, fast_data_lines_i;
   addr_t fast_address_lines_i;
   logic fast_read_write_i, async_cycle_select_n_i, sync_cycle_select_n_i;
   logic bus_strobe_clock_i, word_transfer_enable_n_i, fast_data_lines_oe_n_o, collect_ready_o;
   logic [15:0] fast_data_lines_o, gate_array_wdata_o;
   logic [4:0] gate_array_addr_o;
   logic transfer_ack_n_o, block_available_n_o, word_ready_n_o, fast_bus_irq_n_o;
   logic half_rate_clock_o, gate_array_io_en_o, gate_array_write_o;
   int n_mismatch = 0, checked = 0;
   fast_bus_fifo_port fast_bus_fifo_port_inst (.*);
   cpu_fast_bus_model cpu_fast_bus_model_inst (.clock_i(clock_i),
      .blk_n_i(block_available_n_o), .ack_n_i(transfer_ack_n_o),
      .dev_data_i(fast_data_lines_o), .dev_oe_n_i(fast_data_lines_oe_n_o),
      .data_o(fast_data_lines_i), .rw_o(fast_read_write_i), .addr_o(fast_address_lines_i),
      .async_n_o(async_cycle_select_n_i), .sync_n_o(sync_cycle_select_n_i),
      .strobe_o(bus_strobe_clock_i), .en_n_o(word_transfer_enable_n_i));
   initial forever #25 clock_i = ~clock_i;
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tally_and_finish;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // stream words in; the far side does not drain meanwhile
   task push(input int n, input word_t b);
      for (int i = 0; i < n; i++) begin
         collect_valid_i = 1'b1; collect_data_i = b + i[15:0];
         while (collect_ready_o !== 1'b1) @(negedge clock_i);
         @(negedge clock_i);
      end
      collect_valid_i = 1'b0;
   endtask
   task drain(input int n, input word_t b);
      word_t w;
      logic oe;
      for (int i = 0; i < n; i++) begin
         cpu_fast_bus_model_inst.pop(w, oe);
         chk("word", b + i[15:0], w);
         chk("pop drive", 0, oe);
      end
   endtask
   task t_bus;
      logic oe;
      logic h;
      int wr;
      wr = 0;
      h = half_rate_clock_o;
      @(negedge clock_i);
      chk("half clock", !h, half_rate_clock_o);
      cpu_fast_bus_model_inst.async_cycle(1'b1, oe);
      chk("read drive", 0, oe);
      cpu_fast_bus_model_inst.async_cycle(1'b0, oe);
      chk("write drive", 1, oe);
      chk("ack idle", 1, transfer_ack_n_o);
      fork
         cpu_fast_bus_model_inst.sync_write(5'h15, 16'ha5c3);
         repeat (4) begin
            @(negedge clock_i);
            if (gate_array_write_o === 1'b1) begin
               wr++;
               chk("wdata", 16'ha5c3, gate_array_wdata_o);
            end
         end
      join
      chk("writes", 1, wr[15:0]);
      chk("addr", 5'h15, gate_array_addr_o);
      chk("io off", 0, gate_array_io_en_o);
      $display("t_bus done");
   endtask
   task t_stream;
      push(7, 16'h1000);
      repeat (4) @(negedge clock_i);
      chk("part block", 1, block_available_n_o);
      chk("ready", 0, word_ready_n_o);
      push(1, 16'h1007);
      repeat (3) @(negedge clock_i);
      chk("block", 0, block_available_n_o);
      drain(8, 16'h1000);
      chk("block done", 1, block_available_n_o);
      chk("empty", 1, word_ready_n_o);
      // sixteen words fill the fifo, the last two wait in the skid buffer
      push(18, 16'h2000);
      repeat (2) @(negedge clock_i);
      chk("refused", 0, collect_ready_o);
      chk("full irq", 0, fast_bus_irq_n_o);
      drain(16, 16'h2000);
      chk("irq off", 1, fast_bus_irq_n_o);
      irq_request_i = 1'b1;
      repeat (2) @(negedge clock_i);
      chk("irq", 0, fast_bus_irq_n_o);
      irq_request_i = 1'b0;
      // the two held words must lead the next block, in order
      push(6, 16'h2012);
      drain(8, 16'h2010);
      chk("all gone", 1, word_ready_n_o);
      $display("t_stream done");
   endtask
   initial begin
      #150000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(negedge clock_i);
      chk("reset ack", 1, transfer_ack_n_o);
      chk("reset block", 1, block_available_n_o);
      chk("reset drive", 1, fast_data_lines_oe_n_o);
      repeat (3) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      t_bus;
      t_stream;
      tally_and_finish;
   end
endmodule
`default_nettype wire
